// >>> nirq_align_check.v
// misaligned access detector for one fifo port
`include "nirq_defines.vh"

module nirq_align_check (
  input wire aclk,
  input wire aresetn,
  input wire access,
  input wire [`NIRQ_SZ_W-1:0] access_size,
  input wire limit_hit,
  output reg error
);

  reg [`NIRQ_PTR_W-1:0] byte_ptr;
  reg [`NIRQ_SZ_W-1:0] last_size;
  reg seen;
  wire misaligned;
  wire [`NIRQ_PTR_W-1:0] step;

  // ----------------------------------------------------------------
  // byte pointer and width tracking
  // ----------------------------------------------------------------
  // RL4: width change off byte zero
  assign misaligned = seen && (access_size != last_size) && (byte_ptr != `NIRQ_PTR_ZERO);
  // size code 0 byte, 1 half, 2 word: pointer advances by 2**size
  assign step = (access_size == 2'd0) ? 2'd1 : ((access_size == 2'd1) ? 2'd2 : 2'd0);

  always @(posedge aclk) begin
    if (!aresetn) begin
      byte_ptr <= `NIRQ_PTR_ZERO;
      last_size <= 2'd0;
      seen <= 1'b0;
      error <= 1'b0;
    end else begin
      error <= access && (misaligned || limit_hit);
      if (access) begin
        byte_ptr <= byte_ptr + step;
        last_size <= access_size;
        seen <= 1'b1;
      end
    end
  end

endmodule

// >>> nirq_defines.vh
// register map, field positions and reset values of the interrupt block
`ifndef NIRQ_DEFINES_VH
`define NIRQ_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define NIRQ_OFS_SOURCE 8'h00
`define NIRQ_OFS_MASK 8'h04
`define NIRQ_OFS_CLEAR 8'h08
`define NIRQ_OFS_LEVELS 8'h0c
`define NIRQ_OFS_FLAGS 8'h10

// ----------------------------------------------------------------
// source bit positions
// ----------------------------------------------------------------
`define NIRQ_NSRC 15
`define NIRQ_B_TX_EMPTY 0
`define NIRQ_B_TX_LEVEL 1
`define NIRQ_B_TX_NOTFULL 2
`define NIRQ_B_RX_NONEMPTY 3
`define NIRQ_B_RX_LEVEL 4
`define NIRQ_B_RX_FULL 5
`define NIRQ_B_BUS_PUSH_ERR 6
`define NIRQ_B_BUS_POP_ERR 7
`define NIRQ_B_LINK_PUSH_ERR 8
`define NIRQ_B_LINK_POP_ERR 9
`define NIRQ_B_BLK_READ 10
`define NIRQ_B_BLK_WRITE 11
`define NIRQ_B_WPAR_DONE 12
`define NIRQ_B_RECC_DONE 13
`define NIRQ_B_CORR_DONE 14

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define NIRQ_LVL_W 13
`define NIRQ_LVLS_RX_LSB 16
`define NIRQ_MASK_RESET 32'h0fff_ffff
`define NIRQ_LVL_RESET 13'h0800
`define NIRQ_ZERO32 32'h0000_0000
`define NIRQ_RESP_OKAY 2'b00
`define NIRQ_RESP_SLVERR 2'b10
`define NIRQ_PTR_W 2
`define NIRQ_PTR_ZERO 2'b00
`define NIRQ_SZ_W 2

`endif

// >>> nirq_fifo_model.sv
// queue levels and event pulses of the controller side
module nirq_fifo_model (
  input wire logic aclk,
  output logic [12:0] tx_free,
  output logic [12:0] rx_fill,
  output logic [8:0] ev,
  output logic [1:0] sz
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_free = 13'h0000;
    rx_fill = 13'h0000;
    ev = 9'h000;
    sz = 2'h0;
  end
  task lvl(input int t, input int r);
    @(posedge aclk);
    tx_free <= t[12:0];
    rx_fill <= r[12:0];
  endtask
  // ev order: bus push, bus pop, link push, link pop, then the five done events
  task drive(input logic [8:0] e, input logic [1:0] s);
    @(posedge aclk);
    ev <= e;
    sz <= s;
  endtask
endmodule

// >>> nirq_irq_logic.v
// interrupt source, mask and clear logic with axi4-lite register slave
// Functional notes
// RL1: link receive push error sets bit 8
// RL2: bus read of receive queue error sets 7
// RL3: bus write of transmit queue error sets 6
// RL4: width change off byte zero is misaligned
// RL5: receive queue becoming full sets bit 5
// RL6: receive level above threshold sets bit 4
// RL7: receive queue becoming nonempty sets bit 3
// RL8: transmit queue leaving full sets bit 2
// RL9: transmit free space above threshold sets 1
// RL10: transmit queue becoming empty sets bit 0
// RL11: mask one blocks; all masked after reset
// RL12: each of fifteen sources masked independently
// RL13: writing one to clear register clears
// RL14: raw unmasked sources readable in status register
// RL15: link pop of transmit queue error sets 9
// RL16: block write sets 11, block read 10
// RL17: interrupt when any unmasked source set
// RL18: zero clear ignored; event beats clear
//
// The AXI4-Lite register port is this design's own decision.
`include "nirq_defines.vh"

module nirq_irq_logic (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [`NIRQ_LVL_W-1:0] tx_free_level,
  input wire [`NIRQ_LVL_W-1:0] rx_fill_level,
  input wire bus_tx_push,
  input wire [`NIRQ_SZ_W-1:0] bus_tx_size,
  input wire bus_rx_pop,
  input wire [`NIRQ_SZ_W-1:0] bus_rx_size,
  input wire link_rx_push,
  input wire [`NIRQ_SZ_W-1:0] link_rx_size,
  input wire link_tx_pop,
  input wire [`NIRQ_SZ_W-1:0] link_tx_size,
  input wire block_read_done,
  input wire block_write_done,
  input wire write_parity_done,
  input wire read_ecc_done,
  input wire corrected_data_done,
  output reg irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam [`NIRQ_LVL_W-1:0] FULL_LEVEL = {`NIRQ_LVL_W{1'b1}};

  reg [`NIRQ_NSRC-1:0] irq_raw_source;
  reg [31:0] irq_mask;
  reg [`NIRQ_LVL_W-1:0] tx_threshold;
  reg [`NIRQ_LVL_W-1:0] rx_threshold;
  reg [`NIRQ_NSRC-1:0] next_raw;
  reg [`NIRQ_NSRC-1:0] events;
  reg [`NIRQ_NSRC-1:0] clear_bits;
  reg [31:0] clear_word;
  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg aw_held;
  reg w_held;

  wire tx_empty_ev;
  wire tx_notfull_ev;
  wire tx_above;
  wire rx_nonempty_ev;
  wire rx_full_ev;
  wire rx_above;
  wire bus_push_err;
  wire bus_pop_err;
  wire link_push_err;
  wire link_pop_err;
  wire do_write;

  function [31:0] strb_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  function reg_mapped;
    input [7:0] addr;
    begin
      reg_mapped = (addr == `NIRQ_OFS_SOURCE) || (addr == `NIRQ_OFS_MASK) ||
        (addr == `NIRQ_OFS_CLEAR) || (addr == `NIRQ_OFS_LEVELS) ||
        (addr == `NIRQ_OFS_FLAGS);
    end
  endfunction

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  nirq_level_edge u_tx_level (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(tx_free_level),
    .threshold(tx_threshold),
    .full_level(FULL_LEVEL),
    .became_empty(),
    .became_nonempty(),
    .became_full(tx_empty_ev),
    .left_full(),
    .above(tx_above)
  );

  nirq_level_edge u_rx_level (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(rx_fill_level),
    .threshold(rx_threshold),
    .full_level(FULL_LEVEL),
    .became_empty(),
    .became_nonempty(rx_nonempty_ev),
    .became_full(rx_full_ev),
    .left_full(),
    .above(rx_above)
  );

  // transmit queue leaves full when free space rises from zero
  reg tx_prev_nospace;
  reg tx_notfull_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_prev_nospace <= 1'b0;
      tx_notfull_q <= 1'b0;
    end else begin
      tx_prev_nospace <= (tx_free_level == {`NIRQ_LVL_W{1'b0}});
      tx_notfull_q <= tx_prev_nospace && (tx_free_level != {`NIRQ_LVL_W{1'b0}});
    end
  end
  assign tx_notfull_ev = tx_notfull_q;

  // RL3: bus side transmit push check
  nirq_align_check u_bus_push (
    .aclk(aclk),
    .aresetn(aresetn),
    .access(bus_tx_push),
    .access_size(bus_tx_size),
    .limit_hit(tx_free_level == {`NIRQ_LVL_W{1'b0}}),
    .error(bus_push_err)
  );

  // RL2: bus side receive pop check
  nirq_align_check u_bus_pop (
    .aclk(aclk),
    .aresetn(aresetn),
    .access(bus_rx_pop),
    .access_size(bus_rx_size),
    .limit_hit(rx_fill_level == {`NIRQ_LVL_W{1'b0}}),
    .error(bus_pop_err)
  );

  // RL1: link side receive push check
  nirq_align_check u_link_push (
    .aclk(aclk),
    .aresetn(aresetn),
    .access(link_rx_push),
    .access_size(link_rx_size),
    .limit_hit(rx_fill_level == FULL_LEVEL),
    .error(link_push_err)
  );

  // RL15: link side transmit pop check
  nirq_align_check u_link_pop (
    .aclk(aclk),
    .aresetn(aresetn),
    .access(link_tx_pop),
    .access_size(link_tx_size),
    .limit_hit(tx_free_level == FULL_LEVEL),
    .error(link_pop_err)
  );

  // ----------------------------------------------------------------
  // raw source latch
  // ----------------------------------------------------------------
  always @* begin
    events = {`NIRQ_NSRC{1'b0}};
    // RL10: transmit empty event
    events[`NIRQ_B_TX_EMPTY] = tx_empty_ev;
    // RL9: transmit space above level
    events[`NIRQ_B_TX_LEVEL] = tx_above;
    // RL8: transmit not full
    events[`NIRQ_B_TX_NOTFULL] = tx_notfull_ev;
    // RL7: receive became nonempty
    events[`NIRQ_B_RX_NONEMPTY] = rx_nonempty_ev;
    // RL6: receive above level
    events[`NIRQ_B_RX_LEVEL] = rx_above;
    // RL5: receive became full
    events[`NIRQ_B_RX_FULL] = rx_full_ev;
    events[`NIRQ_B_BUS_PUSH_ERR] = bus_push_err;
    events[`NIRQ_B_BUS_POP_ERR] = bus_pop_err;
    events[`NIRQ_B_LINK_PUSH_ERR] = link_push_err;
    events[`NIRQ_B_LINK_POP_ERR] = link_pop_err;
    // RL16: block transfer completion
    events[`NIRQ_B_BLK_READ] = block_read_done;
    events[`NIRQ_B_BLK_WRITE] = block_write_done;
    events[`NIRQ_B_WPAR_DONE] = write_parity_done;
    events[`NIRQ_B_RECC_DONE] = read_ecc_done;
    events[`NIRQ_B_CORR_DONE] = corrected_data_done;
  end

  always @* begin
    clear_word = `NIRQ_ZERO32;
    // RL13: write one to clear
    if (do_write && (wr_addr == `NIRQ_OFS_CLEAR)) begin
      clear_word = strb_merge(`NIRQ_ZERO32, wr_data, wr_strb);
    end
    // only the implemented source bits can be cleared
    clear_bits = clear_word[`NIRQ_NSRC-1:0];
    // RL18: set wins over clear
    next_raw = (irq_raw_source & ~clear_bits) | events;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_raw_source <= {`NIRQ_NSRC{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_raw_source <= next_raw;
      // RL17: unmasked set source drives irq
      irq <= |(next_raw & ~irq_mask[`NIRQ_NSRC-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NIRQ_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= `NIRQ_ZERO32;
      wr_strb <= 4'h0;
      // RL11: every source masked at reset
      irq_mask <= `NIRQ_MASK_RESET;
      tx_threshold <= `NIRQ_LVL_RESET;
      rx_threshold <= `NIRQ_LVL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= {s_axi_awaddr[7:2], 2'b00};
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_mapped(wr_addr) ? `NIRQ_RESP_OKAY : `NIRQ_RESP_SLVERR;
        // RL12: per-bit independent mask
        if (wr_addr == `NIRQ_OFS_MASK) begin
          irq_mask <= strb_merge(irq_mask, wr_data, wr_strb);
        end
        if (wr_addr == `NIRQ_OFS_LEVELS) begin
          tx_threshold <= wr_data[`NIRQ_LVL_W-1:0];
          rx_threshold <= wr_data[`NIRQ_LVLS_RX_LSB +: `NIRQ_LVL_W];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `NIRQ_ZERO32;
      s_axi_rresp <= `NIRQ_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `NIRQ_RESP_OKAY;
        s_axi_rdata <= `NIRQ_ZERO32;
        case ({s_axi_araddr[7:2], 2'b00})
          // RL14: raw unmasked status
          `NIRQ_OFS_SOURCE: s_axi_rdata <= {{(32-`NIRQ_NSRC){1'b0}}, irq_raw_source};
          `NIRQ_OFS_MASK: s_axi_rdata <= irq_mask;
          `NIRQ_OFS_CLEAR: s_axi_rdata <= `NIRQ_ZERO32;
          `NIRQ_OFS_LEVELS: begin
            s_axi_rdata <= {3'b000, rx_threshold, 3'b000, tx_threshold};
          end
          `NIRQ_OFS_FLAGS: begin
            s_axi_rdata <= {{(32-`NIRQ_NSRC){1'b0}},
              irq_raw_source & ~irq_mask[`NIRQ_NSRC-1:0]};
          end
          default: s_axi_rresp <= `NIRQ_RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// >>> nirq_irq_logic_assertions.sv
// bus handshake and interrupt line checker for the interrupt block
module nirq_irq_logic_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst;
    disable iff (1'b0) !aresetn |=> s_axi_awready && s_axi_wready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_wblock;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblock: assert property (p_wblock) else $error("write taken while answering");
  property p_rblock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rblock: assert property (p_rblock) else $error("read taken while answering");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write answer not retired");
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_rans;
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_irqfall;
    $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_irqfall: assert property (p_irqfall) else $error("irq fell without a write");
endmodule

bind nirq_irq_logic nirq_irq_logic_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));

// >>> nirq_irq_logic_tb.sv
// self-checking bench of the interrupt block
module nirq_irq_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp, sz;
  wire [31:0] rdata;
  wire [12:0] txl, rxl;
  wire [8:0] ev;
  int miscompares = 0, checks_done = 0, seed = 22, exp_src = 0, mask = 32'h0fff_ffff;
  int tx_cur = 0, rx_cur = 0, b;
  int tx_thr = 32'h800, rx_thr = 32'h800, ready_dly = 0;

  nirq_fifo_model fm (.aclk(aclk), .tx_free(txl), .rx_fill(rxl), .ev(ev), .sz(sz));
  nirq_irq_logic dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_free_level(txl), .rx_fill_level(rxl),
    .bus_tx_push(ev[0]), .bus_tx_size(sz), .bus_rx_pop(ev[1]), .bus_rx_size(sz),
    .link_rx_push(ev[2]), .link_rx_size(sz), .link_tx_pop(ev[3]), .link_tx_size(sz),
    .block_read_done(ev[4]), .block_write_done(ev[5]), .write_parity_done(ev[6]),
    .read_ecc_done(ev[7]), .corrected_data_done(ev[8]), .irq(irq));

  initial forever #5 aclk = ~aclk;

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input int d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= (ready_dly == 0);
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (n >= ready_dly && !bready) bready <= 1;
    end while (!(bvalid === 1'b1 && bready) && n < 50);
    check("bvalid", bvalid, 1);
    check("bresp", bresp, er);
    bready <= 0;
  endtask
  task rd_chk(input logic [7:0] a, input int e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= (ready_dly == 0);
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
      if (n >= ready_dly && !rready) rready <= 1;
    end while (!(rvalid === 1'b1 && rready) && n < 50);
    check("rvalid", rvalid, 1);
    check("rresp", rresp, er);
    check($sformatf("rdata %h", a), rdata, e);
    rready <= 0;
  endtask
  task irq_chk;
    repeat (3) @(posedge aclk);
    check("irq", irq, (exp_src & ~mask & 32'h7fff) != 0);
  endtask
  task clr(input int c);
    wr(8'h08, c, 2'b00);
    exp_src &= ~c;
    if (tx_cur > tx_thr) exp_src |= 2;
    if (rx_cur > rx_thr) exp_src |= 16;
  endtask
  task lv(input int t, input int r);
    if (t == 32'h1fff && tx_cur != 32'h1fff) exp_src |= 1;
    if (t > tx_thr) exp_src |= 2;
    if (tx_cur == 0 && t != 0) exp_src |= 4;
    if (rx_cur == 0 && r != 0) exp_src |= 8;
    if (r > rx_thr) exp_src |= 16;
    if (r == 32'h1fff && rx_cur != 32'h1fff) exp_src |= 32;
    fm.lvl(t, r);
    tx_cur = t;
    rx_cur = r;
    repeat (4) @(posedge aclk);
    rd_chk(8'h00, exp_src, 2'b00);
  endtask
  task pulse(input int e, input logic [1:0] s);
    fm.drive(e[8:0], s);
    fm.drive(9'h000, s);
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    #200000;
    miscompares++;
    test_done;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd_chk(8'h00, 0, 2'b00);
    rd_chk(8'h04, mask, 2'b00);
    rd_chk(8'h08, 0, 2'b00);
    rd_chk(8'h0c, 32'h0800_0800, 2'b00);
    wr(8'h20, 0, 2'b10);
    rd_chk(8'h20, 0, 2'b10);
    rd_chk(8'h04, mask, 2'b00);
    lv(1, 0);
    lv(32'h801, 1);
    lv(32'h1fff, 32'h801);
    lv(5, 32'h1fff);
    repeat (3) lv($random(seed) & 32'h1fff, $random(seed) & 32'h1fff);
    lv(0, 0);
    clr(32'h7fff);
    rd_chk(8'h00, exp_src, 2'b00);
    lv(32'h100, 32'h100);
    pulse(1, 2);
    pulse(1, 2);
    pulse(1, 0);
    rd_chk(8'h00, exp_src, 2'b00);
    pulse(1, 2);
    exp_src |= 64;
    rd_chk(8'h00, exp_src, 2'b00);
    clr(64);
    lv(0, 0);
    pulse(1, 0);
    pulse(2, 0);
    exp_src |= 32'h00c0;
    lv(32'h1fff, 32'h1fff);
    pulse(4, 0);
    pulse(8, 0);
    exp_src |= 32'h0300;
    rd_chk(8'h00, exp_src, 2'b00);
    for (int i = 4; i < 9; i++) begin
      b = 1 << (i + 6);
      pulse(1 << i, 0);
      exp_src |= b;
      irq_chk;
      mask = 32'h0fff_ffff & ~b;
      wr(8'h04, mask, 2'b00);
      irq_chk;
      clr(b);
      irq_chk;
      rd_chk(8'h00, exp_src, 2'b00);
    end
    pulse(32, 0);
    exp_src |= 32'h0800;
    clr(0);
    rd_chk(8'h00, exp_src, 2'b00);
    // event pulse lands exactly on the clearing write
    fork
      clr(32'h0800);
      begin
        wait (awvalid === 1'b1);
        fm.drive(9'h020, 2'h0);
        fm.drive(9'h000, 2'h0);
      end
    join
    exp_src |= 32'h0800;
    rd_chk(8'h00, exp_src, 2'b00);
    ready_dly = 3;
    wr(8'h0c, 32'h1fff_0100, 2'b00);
    rd_chk(8'h0c, 32'h1fff_0100, 2'b00);
    ready_dly = 0;
    tx_thr = 32'h100;
    rx_thr = 32'h1fff;
    clr(32'h0012);
    rd_chk(8'h00, exp_src, 2'b00);
    repeat (4) begin
      b = 1 << (4 + (($random(seed) & 7) % 5));
      pulse(b, 0);
      exp_src |= b << 6;
      mask = $random(seed) & 32'h7fff;
      wr(8'h04, mask, 2'b00);
      rd_chk(8'h04, mask, 2'b00);
      rd_chk(8'h10, exp_src & ~mask, 2'b00);
      irq_chk;
    end
    // second reset in mid-run, queues idle
    lv(0, 0);
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    exp_src = 0;
    mask = 32'h0fff_ffff;
    tx_thr = 32'h800;
    rx_thr = 32'h800;
    rd_chk(8'h00, 0, 2'b00);
    rd_chk(8'h04, mask, 2'b00);
    rd_chk(8'h0c, 32'h0800_0800, 2'b00);
    irq_chk;
    test_done;
  end
endmodule

// >>> nirq_level_edge.v
// edge and threshold event generator for the fifo level flags
`include "nirq_defines.vh"

module nirq_level_edge (
  input wire aclk,
  input wire aresetn,
  input wire [`NIRQ_LVL_W-1:0] level,
  input wire [`NIRQ_LVL_W-1:0] threshold,
  input wire [`NIRQ_LVL_W-1:0] full_level,
  output reg became_empty,
  output reg became_nonempty,
  output reg became_full,
  output reg left_full,
  output reg above
);

  reg [`NIRQ_LVL_W-1:0] prev;
  wire prev_empty;
  wire prev_full;
  wire now_empty;
  wire now_full;

  assign prev_empty = (prev == {`NIRQ_LVL_W{1'b0}});
  assign prev_full = (prev == full_level);
  assign now_empty = (level == {`NIRQ_LVL_W{1'b0}});
  assign now_full = (level == full_level);

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev <= {`NIRQ_LVL_W{1'b0}};
      became_empty <= 1'b0;
      became_nonempty <= 1'b0;
      became_full <= 1'b0;
      left_full <= 1'b0;
      above <= 1'b0;
    end else begin
      prev <= level;
      became_empty <= now_empty && !prev_empty;
      became_nonempty <= !now_empty && prev_empty;
      became_full <= now_full && !prev_full;
      left_full <= !now_full && prev_full;
      above <= (level > threshold);
    end
  end

endmodule
